// ==== pcs_regs.sv ====
// Notes on behaviour
// - LED-off bit seven forces both indicator outputs of the port high.
// - Bit six disables the port transmitter; clears to zero on reset.
// - Writing one to bit five restarts auto-negotiation, then clears itself.
// - Bit three powers the PHY down while set; zero after reset.
// - Bit two disables automatic crossover; zero keeps it enabled.
// - With crossover manual, bit one picks crossed wiring, zero straight.
// - Port 1 bit zero loops frames at port 1 MAC.
// - Bit zero of ports 3 and 4 loops frames at that MAC.
// - Ports 3 and 4 keep bits seven to one reserved.
// - Status bit five shows link good, bit seven crossover state.
// - Status bit six reads one once auto-negotiation completed.
// - Status bits four to zero show link partner abilities.
// - Port 1 seventh register bit seven loops at port 1 PHY.
// - Port 2 seventh register bit seven loops at port 2 PHY.
// - Bit five electrically isolates the PHY from MII and line.
// - Writing one to bit four soft-resets the PHY, self clearing.
// - Bit three forces link up while set.
// - Bits two to zero show operation mode, one after reset.
// - Sixth control registers sit at 0x2d, 0x3d, 0x4d, 0x5d.
// - Status and seventh registers exist only for ports 1 and 2.
`timescale 1ns/10ps
module pcs_regs (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  input  wire logic [1:0]  phy_mdix_state,
  input  wire logic [1:0]  phy_an_done,
  input  wire logic [1:0]  phy_link_good,
  input  wire logic [9:0]  phy_partner_abil,
  input  wire logic [5:0]  phy_op_mode,
  input  wire logic [1:0]  led_zero_req,
  input  wire logic [1:0]  led_one_req,
  output logic      [1:0]  port_indicator_zero,
  output logic      [1:0]  port_indicator_one,
  output logic      [1:0]  tx_disable,
  output logic      [1:0]  an_restart,
  output logic      [1:0]  power_down,
  output logic      [1:0]  auto_mdix_disable,
  output logic      [1:0]  mdix_force,
  output logic      [3:0]  mac_loopback,
  output logic      [1:0]  phy_loopback,
  output logic      [1:0]  phy_isolate,
  output logic      [1:0]  phy_soft_reset,
  output logic      [1:0]  force_link
);

  localparam int NPHY = 2;
  localparam int NMAC = 4;

  logic [NMAC-1:0][7:0]       ctl6_q;
  logic [NPHY-1:0][7:0]       ctl7_q;
  logic [NPHY-1:0][7:0]       stat_meta_q;
  logic [NPHY-1:0][7:0]       stat_q;
  logic [NPHY*3-1:0]          mode_meta_q;
  logic [NPHY*3-1:0]          mode_q;
  logic [NPHY-1:0]            led0_q;
  logic [NPHY-1:0]            led1_q;
  logic [7:0]                 rdata_d;
  logic [7:0]                 rdata_q;
  logic                       rvalid_q;

  // writable bits of the sixth register, narrower on MAC-only ports
  function automatic logic [7:0] c6_mask(input int p);
    return (p < NPHY) ? pcs_pkg::C6_WMASK_PHY : pcs_pkg::C6_WMASK_MAC;
  endfunction

  // true when the bus writes this register in this cycle
  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && (reg_addr == a);
  endfunction

  //////////////////////////////////////////////////////////////////////////

  // status from the PHY core is asynchronous to us, so two flops first;
  // the fields of one port may settle a cycle apart after a change
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_meta_q <= {NPHY{pcs_pkg::STAT_RST}};
      stat_q      <= {NPHY{pcs_pkg::STAT_RST}};
      mode_meta_q <= {NPHY{pcs_pkg::MODE_RST}};
      mode_q      <= {NPHY{pcs_pkg::MODE_RST}};
    end
    else
    begin
      for (int p = 0; p < NPHY; p++)
      begin
        stat_meta_q[p] <= {phy_mdix_state[p], phy_an_done[p],
                           phy_link_good[p],
                           phy_partner_abil[p*pcs_pkg::ABIL_W +:
                                            pcs_pkg::ABIL_W]};
      end
      stat_q      <= stat_meta_q;
      mode_meta_q <= phy_op_mode;
      mode_q      <= mode_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // sixth control register per port; reserved bits are masked off
  // reserved upper bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl6_q <= {NMAC{pcs_pkg::CTL6_RST}};
    end
    else
    begin
      for (int p = 0; p < NMAC; p++)
      begin
        if (wr_hit(pcs_pkg::CTL6_ADDR[p]))
        begin
          ctl6_q[p] <= reg_wdata & c6_mask(p);
        end
        else
        begin
          ctl6_q[p] <= ctl6_q[p] & ~pcs_pkg::C6_SC_MASK;
        end
      end
    end
  end

  // seventh control register; mode bits are never stored, they come
  // from the PHY on every read
  // soft reset self clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl7_q <= {NPHY{pcs_pkg::CTL7_RST}};
    end
    else
    begin
      for (int p = 0; p < NPHY; p++)
      begin
        if (wr_hit(pcs_pkg::CTL7_ADDR[p]))
        begin
          ctl7_q[p] <= reg_wdata & pcs_pkg::C7_WMASK;
        end
        else
        begin
          ctl7_q[p] <= ctl7_q[p] & ~pcs_pkg::C7_SC_MASK;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////

  // indicators are active low, so blanking means driving them high
  // led blanking
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led0_q <= '1;
      led1_q <= '1;
    end
    else
    begin
      for (int p = 0; p < NPHY; p++)
      begin
        led0_q[p] <= ctl6_q[p][pcs_pkg::C6_LED_OFF] | led_zero_req[p];
        led1_q[p] <= ctl6_q[p][pcs_pkg::C6_LED_OFF] | led_one_req[p];
      end
    end
  end

  // control outputs are the register flops themselves
  always_comb
  begin
    for (int p = 0; p < NPHY; p++)
    begin
      tx_disable[p]        = ctl6_q[p][pcs_pkg::C6_TX_DIS];
      an_restart[p]        = ctl6_q[p][pcs_pkg::C6_AN_RST];
      power_down[p]        = ctl6_q[p][pcs_pkg::C6_PWR_DN];
      auto_mdix_disable[p] = ctl6_q[p][pcs_pkg::C6_MDIX_DIS];
      mdix_force[p]        = ctl6_q[p][pcs_pkg::C6_MDIX_FORCE];
      phy_loopback[p]      = ctl7_q[p][pcs_pkg::C7_PHY_LB];
      phy_isolate[p]       = ctl7_q[p][pcs_pkg::C7_ISOLATE];
      phy_soft_reset[p]    = ctl7_q[p][pcs_pkg::C7_SOFT_RST];
      force_link[p]        = ctl7_q[p][pcs_pkg::C7_FORCE_LINK];
    end
    for (int p = 0; p < NMAC; p++)
    begin
      mac_loopback[p] = ctl6_q[p][pcs_pkg::C6_MAC_LB];
    end
  end

  assign port_indicator_zero = led0_q;
  assign port_indicator_one  = led1_q;

  //////////////////////////////////////////////////////////////////////////

  // read mux; anything unmapped, including reserved slots, reads zero
  // status layout
  always_comb
  begin
    rdata_d = 8'h00;
    for (int p = 0; p < NMAC; p++)
    begin
      if (reg_addr == pcs_pkg::CTL6_ADDR[p])
      begin
        rdata_d = ctl6_q[p];
      end
    end
    for (int p = 0; p < NPHY; p++)
    begin
      if (reg_addr == pcs_pkg::STAT1_ADDR[p])
      begin
        rdata_d = stat_q[p];
      end
      if (reg_addr == pcs_pkg::CTL7_ADDR[p])
      begin
        rdata_d = {ctl7_q[p][7:pcs_pkg::MODE_W],
                   mode_q[p*pcs_pkg::MODE_W +: pcs_pkg::MODE_W]};
      end
    end
  end

  // read data registered; a read in the cycle of a write sees the old
  // value, which keeps the path from write data to read data short
  // live status
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= reg_rd;
      if (reg_rd)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;

  //////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr_bit(logic [7:0] a, int b);
    reg_wr && (reg_addr == a) && reg_wdata[b];
  endsequence

  sequence s_no_wr(logic [7:0] a);
    !(reg_wr && (reg_addr == a));
  endsequence

  sequence s_rd(logic [7:0] a);
    reg_rd && (reg_addr == a);
  endsequence

  for (genvar p = 0; p < NPHY; p++)
  begin : g_chk
    property p_led_off;
      ctl6_q[p][pcs_pkg::C6_LED_OFF]
        |=> port_indicator_zero[p] && port_indicator_one[p];
    endproperty
    a_led_off: assert property (p_led_off)
      else $error("indicator not blanked");

    property p_led_norm;
      !ctl6_q[p][pcs_pkg::C6_LED_OFF]
        |=> port_indicator_zero[p] == $past(led_zero_req[p]);
    endproperty
    a_led_norm: assert property (p_led_norm)
      else $error("indicator does not follow request");

    property p_ctl6_wr;
      reg_wr && (reg_addr == pcs_pkg::CTL6_ADDR[p])
        |=> {tx_disable[p], power_down[p], auto_mdix_disable[p],
             mdix_force[p], mac_loopback[p]}
            == {$past(reg_wdata[6]), $past(reg_wdata[3]),
                $past(reg_wdata[2:0])};
    endproperty
    a_ctl6_wr: assert property (p_ctl6_wr)
      else $error("control six outputs wrong after write");

    property p_an_pulse;
      s_wr_bit(pcs_pkg::CTL6_ADDR[p], pcs_pkg::C6_AN_RST)
        ##1 s_no_wr(pcs_pkg::CTL6_ADDR[p])
        |-> an_restart[p] ##1 !an_restart[p];
    endproperty
    a_an_pulse: assert property (p_an_pulse)
      else $error("restart not a one cycle pulse");

    property p_srst_pulse;
      s_wr_bit(pcs_pkg::CTL7_ADDR[p], pcs_pkg::C7_SOFT_RST)
        ##1 s_no_wr(pcs_pkg::CTL7_ADDR[p])
        |-> phy_soft_reset[p] ##1 !phy_soft_reset[p];
    endproperty
    a_srst_pulse: assert property (p_srst_pulse)
      else $error("soft reset not a one cycle pulse");

    property p_ctl7_wr;
      reg_wr && (reg_addr == pcs_pkg::CTL7_ADDR[p])
        |=> {phy_loopback[p], phy_isolate[p], force_link[p]}
            == {$past(reg_wdata[7]), $past(reg_wdata[5]),
                $past(reg_wdata[3])};
    endproperty
    a_ctl7_wr: assert property (p_ctl7_wr)
      else $error("control seven outputs wrong after write");

    property p_stat_rd;
      s_rd(pcs_pkg::STAT1_ADDR[p]) |=> reg_rvalid
        && reg_rdata == $past(stat_q[p]);
    endproperty
    a_stat_rd: assert property (p_stat_rd)
      else $error("status read does not show phy state");

    property p_mode_rd;
      s_rd(pcs_pkg::CTL7_ADDR[p]) |=> reg_rdata[2:0]
        == $past(mode_q[p*pcs_pkg::MODE_W +: pcs_pkg::MODE_W]);
    endproperty
    a_mode_rd: assert property (p_mode_rd)
      else $error("mode field wrong on read");
  end

  property p_mac_only;
    s_rd(pcs_pkg::CTL6_ADDR[2]) or s_rd(pcs_pkg::CTL6_ADDR[3])
      |=> reg_rdata[7:1] == 7'h00;
  endproperty
  a_mac_only: assert property (p_mac_only)
    else $error("reserved bits set on mac only port");

  property p_mac34;
    reg_wr && (reg_addr == pcs_pkg::CTL6_ADDR[3])
      |=> mac_loopback[3] == $past(reg_wdata[0]) ##1
          mac_loopback[3] || !$past(mac_loopback[3]) || $past(reg_wr);
  endproperty
  a_mac34: assert property (p_mac34)
    else $error("port four loopback not held");

  property p_unmapped;
    s_rd(pcs_pkg::RSVD_ADDR) or s_rd(8'h4e) or s_rd(8'h5f)
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("reserved slot reads nonzero");

endmodule

// ==== pcs_pkg.sv ====
package pcs_pkg;

  // register addresses, index is port number minus one
  localparam logic [3:0][7:0] CTL6_ADDR  = {8'h5d, 8'h4d, 8'h3d, 8'h2d};
  localparam logic [1:0][7:0] STAT1_ADDR = {8'h3e, 8'h2e};
  localparam logic [1:0][7:0] CTL7_ADDR  = {8'h3f, 8'h2f};
  localparam logic [7:0]      RSVD_ADDR  = 8'h1d;

  // sixth control register fields
  localparam int C6_LED_OFF    = 7;
  localparam int C6_TX_DIS     = 6;
  localparam int C6_AN_RST     = 5;
  localparam int C6_PWR_DN     = 3;
  localparam int C6_MDIX_DIS   = 2;
  localparam int C6_MDIX_FORCE = 1;
  localparam int C6_MAC_LB     = 0;

  // seventh control register fields
  localparam int C7_PHY_LB     = 7;
  localparam int C7_ISOLATE    = 5;
  localparam int C7_SOFT_RST   = 4;
  localparam int C7_FORCE_LINK = 3;
  localparam int C7_MODE_LSB   = 0;
  localparam int MODE_W        = 3;

  // first status register fields
  localparam int S1_MDIX       = 7;
  localparam int S1_AN_DONE    = 6;
  localparam int S1_LINK       = 5;
  localparam int ABIL_W        = 5;

  // writable bits and self clearing bits
  localparam logic [7:0] C6_WMASK_PHY = 8'hef;
  localparam logic [7:0] C6_WMASK_MAC = 8'h01;
  localparam logic [7:0] C6_SC_MASK   = 8'h20;
  localparam logic [7:0] C7_WMASK     = 8'hb8;
  localparam logic [7:0] C7_SC_MASK   = 8'h10;

  // values after reset
  localparam logic [7:0]        CTL6_RST = 8'h00;
  localparam logic [7:0]        CTL7_RST = 8'h00;
  localparam logic [7:0]        STAT_RST = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h1;

  // operation mode codes
  localparam logic [MODE_W-1:0] MODE_AN     = 3'h1;
  localparam logic [MODE_W-1:0] MODE_10_HD  = 3'h2;
  localparam logic [MODE_W-1:0] MODE_100_HD = 3'h3;
  localparam logic [MODE_W-1:0] MODE_10_FD  = 3'h5;
  localparam logic [MODE_W-1:0] MODE_100_FD = 3'h6;

endpackage

// ==== tb_pcs_regs.sv ====
`timescale 1ns/10ps
module tb_pcs_regs;
  logic       clk, rst_n, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r, d;
  logic [1:0] mdix, an_done, link, led_z, led_o;
  logic [9:0] abil;
  logic [5:0] mode;
  logic [1:0] ind_z, ind_o, txd, anr, pdn, amd, mdf, plb, iso, srst, flk;
  logic [3:0] mlb;
  int         err_count, num_checks, p;
  // reserved slots probed by the last test
  logic [7:0] rsvd [0:4] = '{8'h1d, 8'h1e, 8'h4e, 8'h5f, 8'h4f};

  pcs_regs pcs_regs_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .phy_mdix_state(mdix), .phy_an_done(an_done),
    .phy_link_good(link), .phy_partner_abil(abil), .phy_op_mode(mode),
    .led_zero_req(led_z), .led_one_req(led_o),
    .port_indicator_zero(ind_z), .port_indicator_one(ind_o),
    .tx_disable(txd), .an_restart(anr), .power_down(pdn),
    .auto_mdix_disable(amd), .mdix_force(mdf), .mac_loopback(mlb),
    .phy_loopback(plb), .phy_isolate(iso), .phy_soft_reset(srst),
    .force_link(flk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // clock, 8 ns period
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, inputs move 1 ns after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask

  // read answer lands exactly one cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    #1 reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk({7'h0, reg_rvalid}, 8'h01);
    v = reg_rdata;
  endtask

  // read-back of a sixth control register: reserved and self clearing
  // bits come back zero, ports 3 and 4 keep only the loopback bit
  function automatic logic [7:0] exp_c6(input int pt, input logic [7:0] v);
    if (pt < 2)
      return v & pcs_pkg::C6_WMASK_PHY & ~pcs_pkg::C6_SC_MASK;
    return v & pcs_pkg::C6_WMASK_MAC;
  endfunction

  // status byte worked out from the PHY inputs of one port
  function automatic logic [7:0] exp_s1(input int pt);
    return {mdix[pt], an_done[pt], link[pt], abil[pt*5 +: 5]};
  endfunction

  task automatic stop_test;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // hang guard, the tests need well under 20 us
  initial
  begin
    #200us;
    err_count++;
    stop_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {mdix, an_done, link, abil, led_z, led_o} = '0;
    mode = 6'h09;
    rst_n = 1'b0;
    void'($urandom(44542));
    repeat (2) @(posedge clk);
    chk({6'h0, ind_z}, 8'h03);
    #1 rst_n = 1'b1;
    // reset values of every register
    for (int i = 0; i < 4; i++)
    begin
      rd(pcs_pkg::CTL6_ADDR[i], r);
      chk(r, 8'h00);
    end
    for (int i = 0; i < 2; i++)
    begin
      rd(pcs_pkg::STAT1_ADDR[i], r);
      chk(r, 8'h00);
      rd(pcs_pkg::CTL7_ADDR[i], r);
      chk(r, 8'h01);
    end
    $display("test reset done");
    // random writes to all sixth control registers
    for (int i = 0; i < 24; i++)
    begin
      p = i % 4;
      d = 8'($urandom) & 8'hdf;
      wr(pcs_pkg::CTL6_ADDR[p], d);
      chk({7'h0, mlb[p]}, {7'h0, d[0]});
      if (p < 2)
        chk({txd[p], pdn[p], amd[p], mdf[p]}, {d[6], d[3:1]});
      rd(pcs_pkg::CTL6_ADDR[p], r);
      chk(r, exp_c6(p, d));
    end
    $display("test control six done");
    // auto-negotiation restart is a single-cycle pulse
    wr(8'h2d, 8'h20);
    chk({6'h0, anr}, 8'h01);
    @(posedge clk);
    #1 chk({6'h0, anr}, 8'h00);
    rd(8'h2d, r);
    chk(r, 8'h00);
    // indicators blank high one cycle behind the control bit
    for (int i = 0; i < 2; i++)
    begin
      wr(pcs_pkg::CTL6_ADDR[i], 8'h80);
      @(posedge clk);
      #1 chk({ind_z[i], ind_o[i]}, 8'h03);
      led_z = 2'($urandom);
      led_o = 2'($urandom);
      wr(pcs_pkg::CTL6_ADDR[i], 8'h00);
      @(posedge clk);
      #1 chk({ind_z[i], ind_o[i]}, {led_z[i], led_o[i]});
    end
    $display("test indicators done");
    // seventh control registers, soft reset pulse and mode codes
    for (int i = 0; i < 10; i++)
    begin
      p = i % 2;
      d = 8'($urandom) & 8'hef;
      mode = (i < 5) ? {2{pcs_pkg::MODE_AN + 3'(i)}} : 6'($urandom);
      wr(pcs_pkg::CTL7_ADDR[p], d);
      chk({plb[p], iso[p], flk[p]}, {d[7], d[5], d[3]});
      repeat (2) @(posedge clk);
      rd(pcs_pkg::CTL7_ADDR[p], r);
      chk(r, (d & 8'ha8) | {5'h0, mode[p*3 +: 3]});
    end
    wr(8'h3f, 8'h10);
    chk({6'h0, srst}, 8'h02);
    @(posedge clk);
    #1 chk({6'h0, srst}, 8'h00);
    $display("test control seven done");
    // status bits follow the PHY inputs after synchronising
    for (int i = 0; i < 12; i++)
    begin
      p = i % 2;
      {mdix, an_done, link} = 6'($urandom);
      abil = 10'($urandom);
      repeat (3) @(posedge clk);
      wr(pcs_pkg::STAT1_ADDR[p], 8'($urandom));
      rd(pcs_pkg::STAT1_ADDR[p], r);
      chk(r, exp_s1(p));
    end
    $display("test status done");
    // reserved slots read zero and ignore writes
    foreach (rsvd[k])
    begin
      wr(rsvd[k], 8'hff);
      rd(rsvd[k], r);
      chk(r, 8'h00);
    end
    $display("test reserved done");
    stop_test;
  end
endmodule
